// ### rtl/compare_pkg.sv
package compare_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_CH       = 3;
    localparam int CNT_W        = 16;
    localparam int MODE_W       = 2;
    localparam int CLK_W        = 3;
    localparam int SYNC_SEL_W   = 5;
    localparam int NUM_CLK_SRC  = 6;
    localparam int NUM_EXT_CLK  = NUM_CLK_SRC - 1;
    localparam int NUM_SYNC_SRC = 21;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;
    localparam int CH_IDX_W     = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets, per channel and global
    localparam logic [ADDR_W-1:0] OFF_CTRL_ONE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL_TWO   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PRIMARY    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SECONDARY  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_COUNTER    = 8'h10;
    localparam logic [ADDR_W-1:0] CH_STRIDE      = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h60;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK   = 8'h64;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTL1_MODE_LSB = 0;
    localparam int CTL1_CLK_LSB  = 2;
    localparam int CTL1_OUT_BIT  = 8;
    localparam int CTL2_SYNC_LSB = 0;
    localparam int CTL2_TRIG_BIT = 7;
    localparam int CTL2_CASC_BIT = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Codes and reset values
    localparam logic [MODE_W-1:0]     MODE_OFF    = 2'h0;
    localparam logic [MODE_W-1:0]     MODE_SINGLE = 2'h1;
    localparam logic [MODE_W-1:0]     MODE_CONT   = 2'h2;
    localparam logic [MODE_W-1:0]     MODE_PWM    = 2'h3;
    localparam logic [SYNC_SEL_W-1:0] SYNC_FREE   = 5'h00;
    localparam logic [CNT_W-1:0]      CNT_ZERO    = 16'h0000;
    localparam logic [CNT_W-1:0]      CNT_MAX     = 16'hffff;
    localparam logic [DATA_W-1:0]     DATA_ZERO   = 32'h0000_0000;

    typedef enum logic [2:0] {
        R_CTRL_ONE, R_CTRL_TWO, R_PRIMARY, R_SECONDARY,
        R_COUNTER, R_STATUS, R_MASK, R_NONE
    } reg_kind_e;

    typedef struct packed {
        reg_kind_e           kind;
        logic [CH_IDX_W-1:0] ch;
    } decode_s;

    // Map a byte address onto a register kind and channel
    function automatic decode_s decode_addr(input logic [ADDR_W-1:0] addr, input int nch);
        decode_s             d;
        logic [ADDR_W-1:0]   base;
        d.kind = R_NONE;
        d.ch   = '0;
        if (addr == OFF_INT_STATUS) d.kind = R_STATUS;
        if (addr == OFF_INT_MASK) d.kind = R_MASK;
        for (int c = 0; c < nch; c++) begin
            base = ADDR_W'(c) * CH_STRIDE;
            if (addr == base + OFF_CTRL_ONE) d = '{R_CTRL_ONE, CH_IDX_W'(c)};
            if (addr == base + OFF_CTRL_TWO) d = '{R_CTRL_TWO, CH_IDX_W'(c)};
            if (addr == base + OFF_PRIMARY) d = '{R_PRIMARY, CH_IDX_W'(c)};
            if (addr == base + OFF_SECONDARY) d = '{R_SECONDARY, CH_IDX_W'(c)};
            if (addr == base + OFF_COUNTER) d = '{R_COUNTER, CH_IDX_W'(c)};
        end
        return d;
    endfunction

endpackage

// ### rtl/pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] pin_in,
    // Filtered rising edges
    output logic      [WIDTH-1:0] rise
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
    } sync_s;

    sync_s cur_reg;
    sync_s cur_next;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync needs at least one input");
        end
    endgenerate

    // Level moves only when the second and third stages agree
    always_comb begin
        cur_next      = cur_reg;
        cur_next.s1   = pin_in;
        cur_next.s2   = cur_reg.s1;
        cur_next.s3   = cur_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (cur_reg.s2[i] == cur_reg.s3[i]) cur_next.lvl[i] = cur_reg.s3[i];
        end
        cur_next.rise = cur_next.lvl & ~cur_reg.lvl;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign rise = cur_reg.rise;

endmodule

// ### rtl/compare_output.sv
module compare_output (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // Mode and match events
    input  wire logic [compare_pkg::MODE_W-1:0]    mode,
    input  wire logic                              hit_pri,
    input  wire logic                              hit_sec,
    // Waveform
    output logic                                   out_level
);

    typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_DONE} out_state_e;

    typedef struct packed {
        out_state_e                   st;
        logic [compare_pkg::MODE_W-1:0] last_mode;
        logic                         lvl;
    } out_s;

    out_s cur_reg;
    out_s cur_next;

    // Pulse and PWM waveform sequencing
    always_comb begin
        cur_next           = cur_reg;
        cur_next.last_mode = mode;
        if (mode != cur_reg.last_mode) begin
            cur_next.st  = ST_IDLE;
            cur_next.lvl = 1'b0;
        end else begin
            case (mode)
                compare_pkg::MODE_SINGLE, compare_pkg::MODE_CONT: begin
                    case (cur_reg.st)
                        ST_IDLE: begin
                            if (hit_pri) begin
                                cur_next.st  = ST_ACTIVE;
                                cur_next.lvl = 1'b1;
                            end
                        end
                        ST_ACTIVE: begin
                            if (hit_sec) begin
                                cur_next.lvl = 1'b0;
                                cur_next.st  = (mode == compare_pkg::MODE_CONT) ? ST_IDLE
                                                                               : ST_DONE;
                            end
                        end
                        ST_DONE: cur_next.lvl = 1'b0;
                        default: cur_next.st = ST_IDLE;
                    endcase
                end
                compare_pkg::MODE_PWM: begin
                    // Secondary match starts a period, primary match ends the duty
                    if (hit_sec) cur_next.lvl = 1'b1;
                    else if (hit_pri) cur_next.lvl = 1'b0;
                    cur_next.st = ST_ACTIVE;
                end
                default: begin
                    cur_next.st  = ST_IDLE;
                    cur_next.lvl = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '{ST_IDLE, compare_pkg::MODE_OFF, 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign out_level = cur_reg.lvl;

endmodule

// ### rtl/compare_timer.sv
// Summary of operation
// - Three independent compare units, each driving pulse or PWM output.
// - Free running: 16-bit counter counts up, wraps from all ones to zero.
// - Event on each running clock tick at which counter equals the primary or the secondary period.
// - Synchronous: counts once clocked, counter cleared on each sync event.
// - Trigger: counter held until a sync event, then allowed to run.
// - Sync select zero means free running; nonzero means sync or trigger.
// - Second control bit 7 set picks trigger, cleared picks synchronous.
// - Sync select picks one of twenty-one sync or trigger sources.
// - By default each unit uses its own 16-bit counter and periods.
// - Cascaded: even unit gives low half, next odd unit high half.
// - Cascaded: low half wraparound increments the paired high half.
// - Each unit holds separate primary and secondary period registers.
// - Single pulse, continuous pulses and continuous PWM output modes.
// - Each counter clocked from one of six selectable clock sources.
module compare_timer #(
    parameter int NUM_CH = compare_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    // APB slave
    input  wire logic [compare_pkg::ADDR_W-1:0]      paddr,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [compare_pkg::DATA_W-1:0]      pwdata,
    output logic      [compare_pkg::DATA_W-1:0]      prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // External clock and sync sources
    input  wire logic [compare_pkg::NUM_EXT_CLK-1:0] ext_clk,
    input  wire logic [compare_pkg::NUM_SYNC_SRC-NUM_CH-1:0] ext_sync,
    // Compare outputs and interrupt
    output logic      [NUM_CH-1:0]                   compare_out,
    output logic                                     irq
);

    localparam int EXT_SYNC_W = compare_pkg::NUM_SYNC_SRC - NUM_CH;
    localparam int CNT_W      = compare_pkg::CNT_W;
    localparam int MODE_W     = compare_pkg::MODE_W;
    localparam int CLK_W      = compare_pkg::CLK_W;
    localparam int SEL_W      = compare_pkg::SYNC_SEL_W;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [NUM_CH-1:0][CNT_W-1:0]  cnt;
        logic [NUM_CH-1:0][CNT_W-1:0]  pri;
        logic [NUM_CH-1:0][CNT_W-1:0]  sec;
        logic [NUM_CH-1:0][MODE_W-1:0] mode;
        logic [NUM_CH-1:0][CLK_W-1:0]  clk_sel;
        logic [NUM_CH-1:0][SEL_W-1:0]  sync_sel;
        logic [NUM_CH-1:0]             trig;
        logic [NUM_CH-1:0]             casc;
        logic [NUM_CH-1:0]             trig_run;
        logic [NUM_CH-1:0]             hit_pri;
        logic [NUM_CH-1:0]             hit_sec;
        logic [NUM_CH-1:0]             status;
        logic [NUM_CH-1:0]             mask;
        logic                          irq;
        logic                          pready;
        logic                          pslverr;
        logic [compare_pkg::DATA_W-1:0] prdata;
    } state_s;

    state_s                           cur_reg;
    state_s                           cur_next;
    logic [compare_pkg::NUM_EXT_CLK-1:0] ext_clk_rise;
    logic [EXT_SYNC_W-1:0]            ext_sync_rise;
    logic [NUM_CH-1:0]                out_level;

    generate
        if (NUM_CH < 1 || NUM_CH > 3 || EXT_SYNC_W < 1) begin : g_bad_count
            $error("compare_timer supports one to three channels");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Selection helpers

    // Clock source 0 is every pclk edge, 1 to 5 are external rising edges
    function automatic logic pick_tick(input logic [compare_pkg::NUM_CLK_SRC-1:0] v,
                                       input logic [CLK_W-1:0] s);
        pick_tick = 1'b0;
        for (int k = 0; k < compare_pkg::NUM_CLK_SRC; k++) begin
            if (s == CLK_W'(k)) pick_tick = v[k];
        end
    endfunction

    // Sync source n picks vector bit n-1; zero and out-of-range pick nothing
    function automatic logic pick_sync(input logic [compare_pkg::NUM_SYNC_SRC-1:0] v,
                                       input logic [SEL_W-1:0] s);
        pick_sync = 1'b0;
        for (int k = 0; k < compare_pkg::NUM_SYNC_SRC; k++) begin
            if (s == SEL_W'(k + 1)) pick_sync = v[k];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    pin_sync #(
        .WIDTH (compare_pkg::NUM_EXT_CLK + EXT_SYNC_W)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({ext_sync, ext_clk}),
        .rise    ({ext_sync_rise, ext_clk_rise})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [NUM_CH-1:0]                      tick;
        logic [NUM_CH-1:0]                      run;
        logic [NUM_CH-1:0]                      zap;
        logic [NUM_CH-1:0]                      shot;
        logic [NUM_CH-1:0]                      pwm;
        logic [NUM_CH-1:0]                      mp;
        logic [NUM_CH-1:0]                      ms;
        logic [NUM_CH-1:0]                      wrap;
        logic [NUM_CH-1:0]                      carry;
        logic [NUM_CH-1:0]                      step;
        logic [NUM_CH-1:0]                      w1c;
        logic [compare_pkg::NUM_SYNC_SRC-1:0]   sync_vec;
        logic                                   free;
        logic                                   joined;
        logic                                   rd_phase;
        logic                                   wr_phase;
        logic [compare_pkg::DATA_W-1:0]         rd;
        compare_pkg::decode_s                   dec;
        tick     = '0;
        run      = '0;
        zap      = '0;
        shot     = '0;
        pwm      = '0;
        mp       = '0;
        ms       = '0;
        wrap     = '0;
        carry    = '1;
        step     = '0;
        w1c      = '0;
        free     = 1'b0;
        joined   = 1'b0;
        rd       = compare_pkg::DATA_ZERO;
        cur_next = cur_reg;

        // Sync sources: own channels' events first, then external edges
        sync_vec = {ext_sync_rise, cur_reg.hit_pri | cur_reg.hit_sec};
        dec      = compare_pkg::decode_addr(paddr, NUM_CH);
        rd_phase = psel && penable && !cur_reg.pready;
        wr_phase = psel && penable && cur_reg.pready && pwrite;

        // Per-channel mode, clock and sync decisions
        for (int i = 0; i < NUM_CH; i++) begin
            free    = (cur_reg.sync_sel[i] == compare_pkg::SYNC_FREE);
            tick[i] = pick_tick({ext_clk_rise, 1'b1}, cur_reg.clk_sel[i]);
            shot[i] = !free && pick_sync(sync_vec, cur_reg.sync_sel[i]);
            run[i]  = (cur_reg.mode[i] != compare_pkg::MODE_OFF) &&
                      (free || !cur_reg.trig[i] || cur_reg.trig_run[i]);
            zap[i]  = shot[i] && !cur_reg.trig[i];
            pwm[i]  = (cur_reg.mode[i] == compare_pkg::MODE_PWM);
            mp[i]   = (cur_reg.cnt[i] == cur_reg.pri[i]);
            ms[i]   = (cur_reg.cnt[i] == cur_reg.sec[i]);
            wrap[i] = (cur_reg.cnt[i] == compare_pkg::CNT_MAX);
            if (shot[i] && cur_reg.trig[i]) cur_next.trig_run[i] = 1'b1;
        end

        // Pairs: even index is the low half, the next index the high half
        for (int i = 0; i + 1 < NUM_CH; i += 2) begin
            joined = cur_reg.casc[i] && cur_reg.casc[i + 1];
            if (joined) begin
                mp[i]        = mp[i] && mp[i + 1];
                ms[i]        = ms[i] && ms[i + 1];
                mp[i + 1]    = mp[i];
                ms[i + 1]    = ms[i];
                tick[i + 1]  = tick[i];
                run[i + 1]   = run[i];
                zap[i + 1]   = zap[i];
                pwm[i + 1]   = pwm[i];
                carry[i + 1] = wrap[i];
            end
        end

        // Counters and match events
        for (int i = 0; i < NUM_CH; i++) begin
            step[i] = run[i] && tick[i];
            if (zap[i] || (step[i] && pwm[i] && ms[i])) begin
                cur_next.cnt[i] = compare_pkg::CNT_ZERO;
            end else if (step[i] && carry[i]) begin
                cur_next.cnt[i] = cur_reg.cnt[i] + 1'b1;
            end
            cur_next.hit_pri[i] = step[i] && mp[i];
            cur_next.hit_sec[i] = step[i] && ms[i];
        end

        // Read data captured in the wait cycle of the access phase
        case (dec.kind)
            compare_pkg::R_CTRL_ONE: begin
                rd[compare_pkg::CTL1_MODE_LSB +: MODE_W] = cur_reg.mode[dec.ch];
                rd[compare_pkg::CTL1_CLK_LSB +: CLK_W]   = cur_reg.clk_sel[dec.ch];
                rd[compare_pkg::CTL1_OUT_BIT]            = out_level[dec.ch];
            end
            compare_pkg::R_CTRL_TWO: begin
                rd[compare_pkg::CTL2_SYNC_LSB +: SEL_W] = cur_reg.sync_sel[dec.ch];
                rd[compare_pkg::CTL2_TRIG_BIT]          = cur_reg.trig[dec.ch];
                rd[compare_pkg::CTL2_CASC_BIT]          = cur_reg.casc[dec.ch];
            end
            compare_pkg::R_PRIMARY:   rd[CNT_W-1:0] = cur_reg.pri[dec.ch];
            compare_pkg::R_SECONDARY: rd[CNT_W-1:0] = cur_reg.sec[dec.ch];
            compare_pkg::R_COUNTER:   rd[CNT_W-1:0] = cur_reg.cnt[dec.ch];
            compare_pkg::R_STATUS:    rd[NUM_CH-1:0] = cur_reg.status;
            compare_pkg::R_MASK:      rd[NUM_CH-1:0] = cur_reg.mask;
            default:                  rd = compare_pkg::DATA_ZERO;
        endcase

        // APB handshake: one wait cycle, then completion
        cur_next.pready  = rd_phase;
        cur_next.pslverr = rd_phase && (dec.kind == compare_pkg::R_NONE);
        cur_next.prdata  = (rd_phase && !pwrite) ? rd : compare_pkg::DATA_ZERO;

        // Writes take effect on the completing edge
        if (wr_phase) begin
            case (dec.kind)
                compare_pkg::R_CTRL_ONE: begin
                    cur_next.mode[dec.ch]    = pwdata[compare_pkg::CTL1_MODE_LSB +: MODE_W];
                    cur_next.clk_sel[dec.ch] = pwdata[compare_pkg::CTL1_CLK_LSB +: CLK_W];
                end
                compare_pkg::R_CTRL_TWO: begin
                    cur_next.sync_sel[dec.ch] = pwdata[compare_pkg::CTL2_SYNC_LSB +: SEL_W];
                    cur_next.trig[dec.ch]     = pwdata[compare_pkg::CTL2_TRIG_BIT];
                    cur_next.casc[dec.ch]     = pwdata[compare_pkg::CTL2_CASC_BIT];
                    cur_next.trig_run[dec.ch] = 1'b0;
                end
                compare_pkg::R_PRIMARY:   cur_next.pri[dec.ch] = pwdata[CNT_W-1:0];
                compare_pkg::R_SECONDARY: cur_next.sec[dec.ch] = pwdata[CNT_W-1:0];
                compare_pkg::R_STATUS:    w1c = pwdata[NUM_CH-1:0];
                compare_pkg::R_MASK:      cur_next.mask = pwdata[NUM_CH-1:0];
                default:                  w1c = '0;
            endcase
        end

        // Sticky event flags: a new event wins over a clear in the same cycle
        cur_next.status = (cur_reg.status & ~w1c) | cur_next.hit_pri | cur_next.hit_sec;
        cur_next.irq    = |(cur_next.status & cur_next.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output waveform generators

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_out
            compare_output u_out (
                .pclk      (pclk),
                .presetn   (presetn),
                .mode      (cur_reg.mode[g]),
                .hit_pri   (cur_reg.hit_pri[g]),
                .hit_sec   (cur_reg.hit_sec[g]),
                .out_level (out_level[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign compare_out = out_level;
    assign irq         = cur_reg.irq;
    assign pready      = cur_reg.pready;
    assign pslverr     = cur_reg.pslverr;
    assign prdata      = cur_reg.prdata;

endmodule

// ### sim/compare_timer_checker.sv
module compare_timer_checker #(
    parameter int NUM_CH = compare_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic                                          pclk,
    input wire logic                                          presetn,
    // APB
    input wire logic [compare_pkg::ADDR_W-1:0]                paddr,
    input wire logic                                          psel,
    input wire logic                                          penable,
    input wire logic                                          pwrite,
    input wire logic [compare_pkg::DATA_W-1:0]                pwdata,
    input wire logic [compare_pkg::DATA_W-1:0]                prdata,
    input wire logic                                          pready,
    input wire logic                                          pslverr,
    // Sources and outputs
    input wire logic [compare_pkg::NUM_EXT_CLK-1:0]           ext_clk,
    input wire logic [compare_pkg::NUM_SYNC_SRC-NUM_CH-1:0]   ext_sync,
    input wire logic [NUM_CH-1:0]                             compare_out,
    input wire logic                                          irq
);
    ////////////////////////////////////////
    // Decode and configuration-seen flag
    logic mapped;
    logic cfg_reg;
    assign mapped = (paddr == 8'h60) || (paddr == 8'h64) || ((int'(paddr[7:5]) < NUM_CH)
        && (paddr[4:0] inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10}));
    // Set once any mode write is attempted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cfg_reg <= 1'b0;
        else if (psel && penable && pwrite && paddr[4:0] == 5'h00 && paddr < 8'h60)
            cfg_reg <= 1'b1;
    end
    ////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_decode_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    rdata_idle_a: assert property (!pready |-> prdata == '0) else $error("prdata not zero when idle");
    irq_fall_a: assert property ($fell(irq) |-> $past(pready && pwrite))
        else $error("irq fell without a write");
    idle_out_a: assert property (!cfg_reg |-> compare_out == '0)
        else $error("output moved with all units off");
    idle_count_a: assert property (pready && !pwrite && !cfg_reg && paddr[4:0] == 5'h10
        |-> prdata == '0) else $error("counter moved with unit off");
    irq_status_a: assert property ($past(irq) && pready && !pwrite && paddr == 8'h60
        |-> prdata[NUM_CH-1:0] != '0) else $error("irq with empty status");
endmodule

bind compare_timer compare_timer_checker #(.NUM_CH(NUM_CH)) u_chk (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
    .ext_sync(ext_sync), .compare_out(compare_out), .irq(irq));

// ### sim/compare_timer_test.sv
module compare_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sync0 = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, rnd = 32'h4870, prdata;
    logic [4:0]  ext_clk = '0;
    logic [16:0] ext_rnd = '0;
    logic [2:0]  compare_out;
    logic        pready, pslverr, irq;
    logic [33:0] exp_q[$], mon_e;
    logic [15:0] pd;
    int          error_cnt = 0, cmp_count = 0, hi = 0;

    ////////////////////////////////////////
    // Clock and design
    always #25 pclk = ~pclk;
    compare_timer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk(ext_clk), .ext_sync({ext_rnd, sync0}),
        .compare_out(compare_out), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random activity on unused clock and sync pins
    always @(posedge pclk) begin
        rnd <= lfsr(rnd);
        ext_clk <= rnd[4:0];
        ext_rnd <= rnd[22:6];
    end

    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One APB transfer; e holds check-data flag, error and data
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [33:0] e);
        int k;
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 34'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b0, 32'h0, {2'b10, d});
    endtask

    // Compare each answer with the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            mon_e = exp_q.pop_front();
            check({31'h0, pslverr}, {31'h0, mon_e[32]});
            if (mon_e[33]) check(prdata, mon_e[31:0]);
        end
    end

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h10, 32'h0);
        apb(8'h7c, 1'b0, 32'h0, {2'b11, 32'h0});
        apb(8'h7c, 1'b1, 32'hffff, {2'b01, 32'h0});
        for (int c = 1; c < 3; c++) begin
            pd = rnd[15:0];
            wr(8'(c * 32 + 8), {16'h0, pd});
            wr(8'(c * 32 + 12), {16'h0, ~pd});
            rd(8'(c * 32 + 8), {16'h0, pd});
            rd(8'(c * 32 + 12), {16'h0, ~pd});
        end
        wr(8'h44, 32'hffff_ffff);
        rd(8'h44, 32'h0000_019f);
        wr(8'h08, 32'h4);
        wr(8'h0c, 32'h9);
        wr(8'h00, 32'h2);
        rd(8'h10, 32'h2);
        rd(8'h10, 32'h6);
        wr(8'h28, 32'h4);
        wr(8'h2c, 32'h9);
        wr(8'h20, 32'h3);
        repeat (20) @(posedge pclk);
        repeat (100) begin
            @(posedge pclk);
            hi += int'(compare_out[1] === 1'b1);
        end
        check(32'(hi), 32'h32);
        wr(8'h48, 32'h3);
        wr(8'h4c, 32'h3);
        wr(8'h44, 32'h84);
        wr(8'h40, 32'h2);
        rd(8'h50, 32'h0);
        rd(8'h60, 32'h3);
        sync0 <= 1'b1;
        repeat (3) @(posedge pclk);
        sync0 <= 1'b0;
        repeat (20) @(posedge pclk);
        rd(8'h60, 32'h7);
        wr(8'h64, 32'h4);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(8'h60, 32'h4);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd(8'h60, 32'h3);
        wr(8'h28, 32'h1);
        wr(8'h24, 32'h100);
        wr(8'h04, 32'h104);
        wr(8'h60, 32'h3);
        sync0 <= 1'b1;
        repeat (3) @(posedge pclk);
        sync0 <= 1'b0;
        repeat (20) @(posedge pclk);
        rd(8'h10, 32'h14);
        rd(8'h60, 32'h0);
        rd(8'h30, 32'h0);
        repeat (65536) @(posedge pclk);
        rd(8'h60, 32'h7);
        rd(8'h30, 32'h1);
        final_report();
    end
    // Watchdog
    initial begin
        repeat (70000) @(posedge pclk);
        error_cnt++;
        final_report();
    end
endmodule
